// file: pmcc_pkg.sv
// pmcc_pkg: register map, field layout, reset values, modes and state record
package pmcc_pkg;
    localparam logic [3:0]  REG_REGULATOR   = 4'h0;
    localparam logic [3:0]  REG_PLL_CONTROL = 4'h4;
    localparam logic [3:0]  REG_PLL_DIVIDE  = 4'h8;
    localparam logic [3:0]  REG_STATUS      = 4'hc;
    localparam int          LVL_LSB         = 0;
    localparam int          VCODE_LSB       = 4;
    localparam int          MULT_LSB        = 0;
    localparam int          BYPASS_BIT      = 8;
    localparam int          PLLEN_BIT       = 9;
    localparam int          SLEEP_CMD_BIT   = 12;
    localparam int          DEEP_CMD_BIT    = 13;
    localparam int          SSEL_LSB        = 0;
    localparam int          CSEL_LSB        = 4;
    localparam int          ST_MODE_LSB     = 0;
    localparam int          ST_MULT_LSB     = 8;
    localparam int          ST_PEND_BIT     = 16;
    localparam logic [1:0]  LVL_OFF         = 2'h0;
    localparam logic [1:0]  LVL_RESET       = 2'h3;
    localparam logic [2:0]  VCODE_RESET     = 3'h4;
    localparam logic [5:0]  MULT_RESET      = 6'h0a;
    localparam logic [3:0]  SSEL_RESET      = 4'h5;
    localparam logic [1:0]  CSEL_RESET      = 2'h0;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [2:0] {
        PMCC_FULL_ON   = 3'b000,
        PMCC_ACTIVE    = 3'b001,
        PMCC_SLEEP     = 3'b010,
        PMCC_DEEP      = 3'b011,
        PMCC_HIBERNATE = 3'b100
    } pmcc_mode_t;

    typedef struct packed {
        logic        awvalid;
        logic [3:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [3:0]  araddr;
        logic        rready;
    } pmcc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pmcc_axi_rsp_t;

    typedef struct packed {
        logic        core_run;    // core clock ungated
        logic        sys_run;     // system clock ungated
        logic        core_tick;   // core clock enable at divided rate
        logic        sys_tick;    // system clock enable at divided rate
        logic        pll_en;
        logic        pll_bypass;
        logic [5:0]  pll_mult;
        logic        reg_off;     // regulator shut off, core supply at 0 V
        logic [2:0]  vcore_code;  // 0.85 V + 50 mV per step
        logic        pins_hiz;
        logic        boot_start;
        logic        async_block;
        logic        dma_grant;
        logic        dma_err;
    } pmcc_ctl_t;

    typedef struct packed {
        pmcc_mode_t    mode;
        logic [1:0]    lvl;
        logic [2:0]    vcode;
        logic [5:0]    mult;
        logic          bypass;
        logic          pll_en;
        logic [3:0]    ssel;
        logic [1:0]    csel;
        logic [3:0]    sys_cnt;
        logic [2:0]    core_cnt;
        logic          rtc_prev;
        logic          aw_full;
        logic [3:0]    aw_addr;
        logic          w_full;
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        pmcc_axi_rsp_t rsp;
        pmcc_ctl_t     ctl;
    } pmcc_state_t;
endpackage

// file: pmcc_sync.sv
// pmcc_sync: two-flop synchroniser for the asynchronous wake sources
module pmcc_sync (
    input  wire logic       i_core_clk,  // core clock
    input  wire logic       i_rst_n,     // synchronised reset, active low
    input  wire logic [1:0] i_async,     // raw inputs
    output logic      [1:0] o_sync       // synchronised copies
);
    logic [1:0] meta;

    // idle level is 1 for both: rtc event is inverted by the caller
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta   <= 2'h3;
            o_sync <= 2'h3;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// file: pmcc_top.sv
// pmcc_top: power mode sequencer, clock divide control and register slave
// Function
// - regulator level 00 shuts regulator, stops both clocks, enters hibernate
// - hibernate with io supply only puts pins in high impedance
// - hibernate wakes on rtc wake event or reset pin
// - regulator reactivation starts a boot sequence
// - sleep gates only the core clock; pll and system clock run
// - sleep wake samples bypass: off gives full-on, on gives active
// - system dma to level-one memory is unsupported during sleep
// - deep sleep stops both clocks; exits only by reset or rtc
// - deep sleep exit: rtc lands in active, reset lands in full-on
// - deep sleep blocks asynchronous peripherals from internal resources
// - core voltage programmable in 50 mV steps, 0.85 V to 1.2 V
// - pll multiplier programmable 1x to 63x, reset value 10x
// - all peripherals run from the system clock derived from the pll
// - four-bit system divide field sets ratio 1 to 15
// - system divide write takes effect at once, no relock wait
// - two-bit core divide field selects 1, 2, 4 or 8 on the fly
// - power-up starts in full-on with pll enabled and not bypassed
// - active mode bypasses pll; both clocks run at input clock rate
// - multiplier written in active is held until active mode is left
module pmcc_top
    import pmcc_pkg::*;
(
    input  wire logic          i_core_clk,    // clock, also stands for the pll output
    input  wire logic          i_rstn,        // power-on reset, active low
    input  wire logic          i_rtc_wake,    // rtc wake event, asynchronous
    input  wire logic          i_reset_pin_n, // reset pin, asynchronous, active low
    input  wire logic          i_wake,        // generic sleep wake request
    input  wire logic          i_dma_l1_req,  // system dma request to level-one memory
    input  pmcc_pkg::pmcc_axi_req_t i_axi,    // axi4-lite requests
    output pmcc_pkg::pmcc_axi_rsp_t o_axi,    // axi4-lite responses
    output pmcc_pkg::pmcc_ctl_t     o_ctl,    // clock, power and pin controls
    output pmcc_pkg::pmcc_mode_t    o_mode    // current power mode
);
    import pmcc_pkg::*;

    logic        rst_s1;
    logic        rst_n;
    logic [1:0]  wake_sync;
    logic        rtc_lvl;
    logic        pin_asserted;
    pmcc_state_t st;
    pmcc_state_t next_st;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] read_reg(input pmcc_state_t s, input logic [3:0] a);
        logic [31:0] r;
        r = 32'h0;
        case (a)
            REG_REGULATOR: begin
                r[LVL_LSB +: 2]   = s.lvl;
                r[VCODE_LSB +: 3] = s.vcode;
            end
            REG_PLL_CONTROL: begin
                r[MULT_LSB +: 6] = s.mult;
                r[BYPASS_BIT]    = s.bypass;
                r[PLLEN_BIT]     = s.pll_en;
            end
            REG_PLL_DIVIDE: begin
                r[SSEL_LSB +: 4] = s.ssel;
                r[CSEL_LSB +: 2] = s.csel;
            end
            REG_STATUS: begin
                r[ST_MODE_LSB +: 3] = s.mode;
                r[ST_MULT_LSB +: 6] = s.ctl.pll_mult;
                r[ST_PEND_BIT]      = (s.ctl.pll_mult != s.mult);
            end
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    function automatic logic is_mapped(input logic [3:0] a);
        return (a == REG_REGULATOR) || (a == REG_PLL_CONTROL) ||
               (a == REG_PLL_DIVIDE) || (a == REG_STATUS);
    endfunction

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    pmcc_sync u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (rst_n),
        .i_async    ({i_reset_pin_n, ~i_rtc_wake}),
        .o_sync     (wake_sync)
    );

    assign rtc_lvl      = ~wake_sync[0];
    assign pin_asserted = ~wake_sync[1];

    always_comb begin
        logic        do_wr;
        logic        rtc_evt;
        logic        go_full;
        logic [31:0] wv;
        logic [3:0]  sys_lim;
        logic [2:0]  core_lim;
        next_st          = st;
        do_wr            = 1'b0;
        go_full          = 1'b0;
        wv               = 32'h0;
        rtc_evt          = rtc_lvl & ~st.rtc_prev;
        sys_lim  = (st.mode == PMCC_ACTIVE) ? 4'h0 : st.ssel - 4'h1;
        core_lim = (st.mode == PMCC_ACTIVE) ? 3'h0 : 3'((4'h1 << st.csel) - 4'h1);
        next_st.rtc_prev = rtc_lvl;
        next_st.ctl.boot_start = 1'b0;
        next_st.ctl.dma_grant  = 1'b0;
        next_st.ctl.dma_err    = 1'b0;

        // write channel: address and data taken independently, then joined
        if (i_axi.awvalid && st.rsp.awready) begin
            next_st.aw_full = 1'b1;
            next_st.aw_addr = i_axi.awaddr;
        end
        if (i_axi.wvalid && st.rsp.wready) begin
            next_st.w_full = 1'b1;
            next_st.w_data = i_axi.wdata;
            next_st.w_strb = i_axi.wstrb;
        end
        if (st.rsp.bvalid && i_axi.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end
        if (st.aw_full && st.w_full && !st.rsp.bvalid) begin
            do_wr              = is_mapped(st.aw_addr) && (st.aw_addr != REG_STATUS);
            next_st.aw_full    = 1'b0;
            next_st.w_full     = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp  = do_wr ? RESP_OKAY : RESP_SLVERR;
            wv = merge(read_reg(st, st.aw_addr), st.w_data, st.w_strb);
        end

        if (do_wr && st.mode != PMCC_HIBERNATE && st.mode != PMCC_DEEP) begin
            case (st.aw_addr)
                REG_REGULATOR: begin
                    next_st.lvl   = wv[LVL_LSB +: 2];
                    next_st.vcode = wv[VCODE_LSB +: 3];
                    if (wv[LVL_LSB +: 2] == LVL_OFF) begin
                        next_st.mode = PMCC_HIBERNATE;
                    end
                end
                REG_PLL_CONTROL: begin
                    if (wv[MULT_LSB +: 6] != 6'h0) begin
                        next_st.mult = wv[MULT_LSB +: 6];
                    end
                    next_st.bypass = wv[BYPASS_BIT];
                    next_st.pll_en = wv[PLLEN_BIT] | (st.mode != PMCC_ACTIVE);
                    if (st.mode == PMCC_FULL_ON && wv[BYPASS_BIT]) begin
                        next_st.mode = PMCC_ACTIVE;
                    end else if (st.mode == PMCC_ACTIVE && !wv[BYPASS_BIT] &&
                                 wv[PLLEN_BIT]) begin
                        next_st.mode = PMCC_FULL_ON;
                        go_full      = 1'b1;
                    end
                    // a disabled pll must be re-enabled before sleep
                    if (wv[DEEP_CMD_BIT]) begin
                        next_st.mode = PMCC_DEEP;
                    end else if (wv[SLEEP_CMD_BIT] && next_st.pll_en) begin
                        next_st.mode = PMCC_SLEEP;
                    end
                end
                REG_PLL_DIVIDE: begin
                    if (wv[SSEL_LSB +: 4] != 4'h0) begin
                        next_st.ssel = wv[SSEL_LSB +: 4];
                    end
                    next_st.csel = wv[CSEL_LSB +: 2];
                end
                default: ;
            endcase
        end

        // wake sequencing
        case (st.mode)
            PMCC_SLEEP: begin
                if (i_wake || rtc_evt) begin
                    next_st.mode = st.bypass ? PMCC_ACTIVE : PMCC_FULL_ON;
                    go_full      = ~st.bypass;
                end
            end
            PMCC_DEEP: begin
                if (pin_asserted) begin
                    next_st.mode = PMCC_FULL_ON;
                    go_full      = 1'b1;
                end else if (rtc_evt) begin
                    next_st.mode = PMCC_ACTIVE;
                end
            end
            PMCC_HIBERNATE: begin
                if (pin_asserted || rtc_evt) begin
                    next_st.mode   = PMCC_FULL_ON;
                    next_st.lvl    = LVL_RESET;
                    next_st.vcode  = VCODE_RESET;
                    next_st.mult   = MULT_RESET;
                    next_st.bypass = 1'b0;
                    next_st.pll_en = 1'b1;
                    next_st.ssel   = SSEL_RESET;
                    next_st.csel   = CSEL_RESET;
                    next_st.ctl.boot_start = 1'b1;
                    go_full        = 1'b1;
                end
            end
            default: ;
        endcase

        // the multiplier only reaches the pll outside active mode
        if (next_st.mode != PMCC_ACTIVE || go_full) begin
            next_st.ctl.pll_mult = next_st.mult;
        end

        // reading: one read at a time, answered the cycle after it is taken
        if (st.rsp.rvalid && i_axi.rready) begin
            next_st.rsp.rvalid = 1'b0;
        end
        if (i_axi.arvalid && st.rsp.arready) begin
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rdata  = read_reg(st, i_axi.araddr);
            next_st.rsp.rresp  = is_mapped(i_axi.araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        next_st.rsp.arready = ~next_st.rsp.rvalid && !(i_axi.arvalid && st.rsp.arready);
        next_st.rsp.awready = ~next_st.aw_full && ~next_st.rsp.bvalid && !do_wr;
        next_st.rsp.wready  = ~next_st.w_full && ~next_st.rsp.bvalid && !do_wr;

        // clock gating and divided enables, divide fields act immediately
        next_st.ctl.core_run = (next_st.mode == PMCC_FULL_ON) ||
                               (next_st.mode == PMCC_ACTIVE);
        next_st.ctl.sys_run  = next_st.ctl.core_run ||
                               (next_st.mode == PMCC_SLEEP);
        next_st.ctl.pll_bypass = (next_st.mode == PMCC_ACTIVE);
        next_st.ctl.pll_en   = next_st.pll_en && (next_st.mode != PMCC_DEEP) &&
                               (next_st.mode != PMCC_HIBERNATE);
        next_st.ctl.reg_off  = (next_st.mode == PMCC_HIBERNATE);
        next_st.ctl.pins_hiz = (next_st.mode == PMCC_HIBERNATE);
        next_st.ctl.async_block = (next_st.mode == PMCC_DEEP) ||
                                  (next_st.mode == PMCC_HIBERNATE);
        next_st.ctl.vcore_code = next_st.vcode;

        if (!st.ctl.sys_run || st.sys_cnt >= sys_lim) begin
            next_st.sys_cnt = 4'h0;
        end else begin
            next_st.sys_cnt = st.sys_cnt + 4'h1;
        end
        if (!st.ctl.core_run || st.core_cnt >= core_lim) begin
            next_st.core_cnt = 3'h0;
        end else begin
            next_st.core_cnt = st.core_cnt + 3'h1;
        end
        next_st.ctl.sys_tick  = st.ctl.sys_run && (st.sys_cnt >= sys_lim);
        next_st.ctl.core_tick = st.ctl.core_run && (st.core_cnt >= core_lim);

        if (i_dma_l1_req) begin
            next_st.ctl.dma_err   = (st.mode != PMCC_FULL_ON) && (st.mode != PMCC_ACTIVE);
            next_st.ctl.dma_grant = (st.mode == PMCC_FULL_ON) || (st.mode == PMCC_ACTIVE);
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st                 <= '0;
            st.mode            <= PMCC_FULL_ON;
            st.lvl             <= LVL_RESET;
            st.vcode           <= VCODE_RESET;
            st.mult            <= MULT_RESET;
            st.pll_en          <= 1'b1;
            st.ssel            <= SSEL_RESET;
            st.csel            <= CSEL_RESET;
            st.ctl.core_run    <= 1'b1;
            st.ctl.sys_run     <= 1'b1;
            st.ctl.pll_en      <= 1'b1;
            st.ctl.pll_mult    <= MULT_RESET;
            st.ctl.vcore_code  <= VCODE_RESET;
            st.rsp.awready     <= 1'b1;
            st.rsp.wready      <= 1'b1;
            st.rsp.arready     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_axi  = st.rsp;
    assign o_ctl  = st.ctl;
    assign o_mode = st.mode;

    sequence s_hib_wake;
        (st.mode == PMCC_HIBERNATE) && (pin_asserted || (rtc_lvl && !st.rtc_prev));
    endsequence
    sequence s_booted;
        (st.mode == PMCC_FULL_ON) && st.ctl.boot_start && !st.ctl.reg_off;
    endsequence

    a_hib_clocks_off: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (st.mode == PMCC_HIBERNATE) |-> !o_ctl.core_run && !o_ctl.sys_run && o_ctl.reg_off)
        else $error("hibernate with a clock running");
    a_hib_pins_hiz: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        o_ctl.pins_hiz == (o_mode == PMCC_HIBERNATE))
        else $error("pin tristate disagrees with mode");
    a_hib_wake_boot: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        s_hib_wake |=> s_booted)
        else $error("hibernate wake did not boot");
    a_sleep_gating: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (o_mode == PMCC_SLEEP) |-> !o_ctl.core_run && o_ctl.sys_run && o_ctl.pll_en)
        else $error("sleep gating wrong");
    a_sleep_wake: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (st.mode == PMCC_SLEEP) && i_wake |=>
        (o_mode == ($past(st.bypass) ? PMCC_ACTIVE : PMCC_FULL_ON)))
        else $error("sleep wake target wrong");
    a_sleep_dma: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (st.mode == PMCC_SLEEP) && i_dma_l1_req |=> o_ctl.dma_err && !o_ctl.dma_grant)
        else $error("dma served in sleep");
    a_deep_exit: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (st.mode == PMCC_DEEP) && pin_asserted |=> (o_mode == PMCC_FULL_ON))
        else $error("deep sleep reset exit wrong");
    a_deep_stay: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (st.mode == PMCC_DEEP) && !pin_asserted && !(rtc_lvl && !st.rtc_prev) |=>
        (o_mode == PMCC_DEEP) && o_ctl.async_block && !o_ctl.sys_run)
        else $error("deep sleep left without a wake source");
    a_active_bypass: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (o_mode == PMCC_ACTIVE) |-> o_ctl.pll_bypass && o_ctl.core_tick && o_ctl.sys_tick
        or (o_mode != $past(o_mode)))
        else $error("active mode not at input rate");
    a_mult_held: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (o_mode == PMCC_ACTIVE) && $stable(o_mode) |-> $stable(o_ctl.pll_mult))
        else $error("multiplier applied during active");
    a_mult_range: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        o_ctl.pll_mult != 6'h0)
        else $error("multiplier out of range");
endmodule

// file: pmcc_wake_model.sv
// pmcc_wake_model: rtc, reset pin, sleep wake and dma sources beside the block
module pmcc_wake_model (
    input  wire logic i_core_clk,    // block clock
    output logic      o_rtc_wake,    // rtc wake level
    output logic      o_reset_pin_n, // reset pin, active low
    output logic      o_wake,        // sleep wake request
    output logic      o_dma_l1_req   // dma request pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_rtc_wake = 1'b0;
        o_reset_pin_n = 1'b1;
        o_wake = 1'b0;
        o_dma_l1_req = 1'b0;
    end
    // rtc and pin move off the clock edge: they belong to no clock domain
    task automatic rtc_event();
        #3;
        o_rtc_wake = 1'b1;
        repeat (6) @(posedge i_core_clk);
        #3;
        o_rtc_wake = 1'b0;
    endtask
    task automatic pin_event();
        #4;
        o_reset_pin_n = 1'b0;
        repeat (5) @(posedge i_core_clk);
        #4;
        o_reset_pin_n = 1'b1;
    endtask
    // which 0 raises the sleep wake, otherwise a dma request, for one cycle
    task automatic pulse(input int which);
        @(posedge i_core_clk);
        if (which == 0)
            o_wake <= 1'b1;
        else
            o_dma_l1_req <= 1'b1;
        @(posedge i_core_clk);
        o_wake <= 1'b0;
        o_dma_l1_req <= 1'b0;
    endtask
endmodule

// file: power_mode_clock_control_test.sv
// power_mode_clock_control_test: self-checking bench for modes, divides and registers
module power_mode_clock_control_test import pmcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic          clk = 1'b0;
    logic          rstn = 1'b0;
    logic          rtc, pin_n, wake, dma;
    pmcc_axi_req_t axi = '0;
    pmcc_axi_rsp_t rsp;
    pmcc_ctl_t     ctl;
    pmcc_mode_t    mode;
    int            bad_count = 0, n_compared = 0, boots = 0, errs = 0, grants = 0, s, p, v;
    always #5 clk = ~clk;
    // pulses are one cycle wide, so they are counted rather than sampled
    always @(posedge clk) begin
        boots <= boots + int'(ctl.boot_start);
        errs <= errs + int'(ctl.dma_err);
        grants <= grants + int'(ctl.dma_grant);
    end
    pmcc_top pmcc_top_inst (.i_core_clk(clk), .i_rstn(rstn), .i_rtc_wake(rtc),
        .i_reset_pin_n(pin_n), .i_wake(wake), .i_dma_l1_req(dma), .i_axi(axi),
        .o_axi(rsp), .o_ctl(ctl), .o_mode(mode));
    pmcc_wake_model pmcc_wake_model_inst (.i_core_clk(clk), .o_rtc_wake(rtc),
        .o_reset_pin_n(pin_n), .o_wake(wake), .o_dma_l1_req(dma));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        axi.awvalid <= 1'b1;
        axi.awaddr <= a;
        axi.wvalid <= 1'b1;
        axi.wdata <= d;
        axi.wstrb <= 4'hf;
        axi.bready <= 1'b1;
        // no cycle limit: only the watchdog ends a stuck handshake
        while (axi.awvalid || axi.wvalid || !rsp.bvalid) begin
            @(posedge clk);
            if (rsp.awready)
                axi.awvalid <= 1'b0;
            if (rsp.wready)
                axi.wvalid <= 1'b0;
        end
        check(32'(rsp.bresp), 32'(er));
        axi.bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, e, input logic [1:0] er);
        @(posedge clk);
        axi.arvalid <= 1'b1;
        axi.araddr <= a;
        axi.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready)
                axi.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        check(rsp.rdata & m, e);
        check(32'(rsp.rresp), 32'(er));
        axi.rready <= 1'b0;
    endtask
    task automatic wait_mode(input pmcc_mode_t m);
        int t;
        t = 0;
        while (mode !== m && t < 20) begin
            @(posedge clk);
            #1;
            t++;
        end
        check(32'(mode), 32'(m));
    endtask
    // cycles between two ticks, after letting a new divide settle
    task automatic period(input bit core, output int n);
        repeat (3) begin
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (!(core ? ctl.core_tick : ctl.sys_tick) && n < 99);
        end
    endtask
    initial begin
        void'($urandom(18));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        rd(REG_REGULATOR, '1, 32'h43, RESP_OKAY);
        rd(REG_PLL_CONTROL, '1, 32'h20a, RESP_OKAY);
        rd(REG_STATUS, '1, 32'ha00, RESP_OKAY);
        check(32'({ctl.pll_en, ctl.pll_bypass, ctl.core_run}), 32'h5);
        rd(4'h2, '1, 32'h0, RESP_SLVERR);
        wr(REG_STATUS, 32'h1, RESP_SLVERR);
        for (int c = 0; c < 4; c++) begin
            // ratio kept within 1..15, ends of the range forced
            s = (c == 0) ? 15 : (c == 3) ? 1 : 1 + $urandom_range(13);
            wr(REG_PLL_DIVIDE, 32'(s) | (32'(c) << CSEL_LSB), RESP_OKAY);
            period(1'b0, p);
            check(p, s);
            period(1'b1, p);
            check(p, 1 << c);
        end
        v = $urandom_range(7);
        wr(REG_REGULATOR, 32'h3 | (32'(v) << VCODE_LSB), RESP_OKAY);
        check(32'(ctl.vcore_code), v);
        wr(REG_PLL_CONTROL, 32'h23f, RESP_OKAY);
        wr(REG_PLL_CONTROL, 32'h200, RESP_OKAY);
        rd(REG_PLL_CONTROL, 32'h3f, 32'h3f, RESP_OKAY);
        wr(REG_PLL_CONTROL, 32'h30a, RESP_OKAY);
        wait_mode(PMCC_ACTIVE);
        period(1'b0, p);
        check(p, 1);
        wr(REG_PLL_CONTROL, 32'h1114, RESP_OKAY);
        check(32'({mode, ctl.pll_en}), 32'h2);
        wr(REG_PLL_CONTROL, 32'h314, RESP_OKAY);
        rd(REG_STATUS, 32'h10007, 32'h10001, RESP_OKAY);
        wr(REG_PLL_CONTROL, 32'h214, RESP_OKAY);
        wait_mode(PMCC_FULL_ON);
        check(32'(ctl.pll_mult), 32'h14);
        rd(REG_STATUS, 32'h13f07, 32'h1400, RESP_OKAY);
        wr(REG_PLL_CONTROL, 32'h1214, RESP_OKAY);
        wait_mode(PMCC_SLEEP);
        check(32'({ctl.core_run, ctl.sys_run, ctl.pll_en}), 32'h3);
        pmcc_wake_model_inst.pulse(1);
        #30;
        check(errs, 1);
        pmcc_wake_model_inst.pulse(0);
        wait_mode(PMCC_FULL_ON);
        wr(REG_PLL_CONTROL, 32'h314, RESP_OKAY);
        wr(REG_PLL_CONTROL, 32'h1314, RESP_OKAY);
        wait_mode(PMCC_SLEEP);
        pmcc_wake_model_inst.rtc_event();
        wait_mode(PMCC_ACTIVE);
        wr(REG_PLL_CONTROL, 32'h2314, RESP_OKAY);
        wait_mode(PMCC_DEEP);
        check(32'({ctl.core_run, ctl.sys_run, ctl.async_block}), 32'h1);
        pmcc_wake_model_inst.pulse(0);
        #60;
        check(32'(mode), 32'(PMCC_DEEP));
        pmcc_wake_model_inst.rtc_event();
        wait_mode(PMCC_ACTIVE);
        wr(REG_PLL_CONTROL, 32'h214, RESP_OKAY);
        wr(REG_PLL_CONTROL, 32'h2214, RESP_OKAY);
        wait_mode(PMCC_DEEP);
        pmcc_wake_model_inst.pin_event();
        wait_mode(PMCC_FULL_ON);
        for (int k = 1; k < 3; k++) begin
            wr(REG_REGULATOR, 32'h40, RESP_OKAY);
            wait_mode(PMCC_HIBERNATE);
            check(32'({ctl.reg_off, ctl.pins_hiz, ctl.core_run, ctl.sys_run}), 32'hc);
            wr(REG_PLL_DIVIDE, 32'h3, RESP_OKAY);
            if (k == 1)
                pmcc_wake_model_inst.rtc_event();
            else
                pmcc_wake_model_inst.pin_event();
            wait_mode(PMCC_FULL_ON);
            #30;
            check(boots, k);
            rd(REG_PLL_DIVIDE, 32'hf, 32'h5, RESP_OKAY);
        end
        pmcc_wake_model_inst.pulse(1);
        #30;
        check(grants, 1);
        check(errs, 1);
        end_of_test();
    end
    initial begin
        #200us;
        bad_count++;
        end_of_test();
    end
endmodule
